// file: verilog/hes_pkg.sv
package hes_pkg;

  // register map
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_RT_AMP = 8'h02;
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h04;
  localparam logic [7:0] ADDR_SLOT_LAST = 8'h0b;
  localparam logic [7:0] ADDR_LAUNCH = 8'h0c;
  localparam logic [7:0] ADDR_OFS_OVERDRIVE = 8'h0d;
  localparam logic [7:0] ADDR_OFS_SUSTAIN_POS = 8'h0e;
  localparam logic [7:0] ADDR_OFS_SUSTAIN_NEG = 8'h0f;
  localparam logic [7:0] ADDR_OFS_BRAKE = 8'h10;
  localparam logic [7:0] ADDR_VDD = 8'h21;

  // field positions
  localparam int SLOT_COUNT = 8;
  localparam int MODE_PWM_SEL_BIT = 3;
  localparam int MODE_STANDBY_BIT = 6;
  localparam int LAUNCH_BIT = 0;
  localparam int SLOT_WAIT_BIT = 7;

  // values after reset
  localparam logic [7:0] RST_SLOT = 8'h00;
  localparam logic [7:0] RST_OFS = 8'h00;
  localparam logic [7:0] RST_RT_AMP = 8'h00;
  localparam logic [7:0] RST_VDD = 8'h00;
  localparam logic RST_STANDBY = 1'b1;
  localparam logic RST_PWM_SEL = 1'b0;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int PAUSE_UNIT_MS = 10;
  localparam int PAUSE_UNIT_CYCLES = CLK_HZ / 1000 * PAUSE_UNIT_MS;

  typedef enum logic [2:0] {
    MODE_INT = 3'b000,
    MODE_EDGE = 3'b001,
    MODE_LEVEL = 3'b010,
    MODE_ANALOG_PWM = 3'b011,
    MODE_AUDIO = 3'b100,
    MODE_RT_AMP = 3'b101,
    MODE_DIAG = 3'b110,
    MODE_CAL = 3'b111
  } hes_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_PLAY = 2'b10,
    SEQ_PAUSE = 2'b11
  } hes_seq_state_t;

  typedef struct packed {
    logic signed [7:0] overdrive;
    logic signed [7:0] sustain_pos;
    logic signed [7:0] sustain_neg;
    logic signed [7:0] brake;
  } hes_offsets_t;

  typedef struct packed {
    logic [15:0] dur;
    logic signed [7:0] level;
    logic peak_pos;
    logic peak_neg;
    logic is_ramp;
  } hes_seg_t;

  function automatic logic hes_is_continuous(input hes_mode_t m);
    hes_is_continuous = (m == MODE_ANALOG_PWM) || (m == MODE_AUDIO) || (m == MODE_RT_AMP);
  endfunction : hes_is_continuous

  function automatic logic hes_is_triggered(input hes_mode_t m);
    hes_is_triggered = (m == MODE_INT) || (m == MODE_EDGE) || (m == MODE_LEVEL);
  endfunction : hes_is_triggered

endpackage : hes_pkg

// file: verilog/hes_pause_timer.sv
`timescale 1ns/1ps
module hes_pause_timer #(
  parameter int UNIT_CYCLES = hes_pkg::PAUSE_UNIT_CYCLES
) (
  // clock and reset
  input logic clk_i,
  input logic sys_rst_i,
  // control
  input logic start_i,
  input logic abort_i,
  input logic [6:0] units_i,
  // status
  output logic done_o
);
  import hes_pkg::*;

  logic [31:0] cyc;
  logic [6:0] units;
  logic busy;
  logic [31:0] next_cyc;
  logic [6:0] next_units;
  logic next_busy;
  logic next_done;

  always_comb
  begin
    next_cyc = cyc;
    next_units = units;
    next_busy = busy;
    next_done = 1'b0;
    if (abort_i)
    begin
      next_busy = 1'b0;
    end
    else if (start_i)
    begin
      next_busy = 1'b1;
      next_units = units_i;
      next_cyc = 32'h0000_0000;
    end
    else if (busy)
    begin
      if (units == 7'h00)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else if (cyc == 32'(UNIT_CYCLES - 1))
      begin
        next_cyc = 32'h0000_0000;
        next_units = units - 7'h01;
      end
      else
      begin
        next_cyc = cyc + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cyc <= 32'h0000_0000;
      units <= 7'h00;
      busy <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      cyc <= next_cyc;
      units <= next_units;
      busy <= next_busy;
      done_o <= next_done;
    end
  end

endmodule : hes_pause_timer

// file: verilog/hes_offset_adjust.sv
`timescale 1ns/1ps
module hes_offset_adjust (
  // clock and reset
  input logic clk_i,
  input logic sys_rst_i,
  // segment request from the playback engine
  input logic seg_req_i,
  input hes_pkg::hes_seg_t seg_i,
  input logic rom_play_i,
  input hes_pkg::hes_offsets_t offsets_i,
  // adjusted duration
  output logic adj_valid_o,
  output logic [15:0] adj_dur_o
);
  import hes_pkg::*;

  logic signed [7:0] ofs;
  logic signed [17:0] sum;
  logic [15:0] next_dur;

  always_comb
  begin
    if (seg_i.peak_pos)
      ofs = offsets_i.overdrive;
    else if (seg_i.peak_neg)
      ofs = offsets_i.brake;
    else if (seg_i.level >= 0)
      ofs = offsets_i.sustain_pos;
    else
      ofs = offsets_i.sustain_neg;
    sum = $signed({2'b00, seg_i.dur}) + 18'(ofs);
    if (!rom_play_i)
      next_dur = seg_i.dur;
    else if (sum < 0)
      next_dur = 16'h0000;
    else if (sum[16])
      next_dur = 16'hffff;
    else
      next_dur = sum[15:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      adj_valid_o <= 1'b0;
      adj_dur_o <= 16'h0000;
    end
    else
    begin
      adj_valid_o <= seg_req_i;
      adj_dur_o <= seg_req_i ? next_dur : adj_dur_o;
    end
  end

  rom_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    seg_req_i && !rom_play_i |=> adj_valid_o && adj_dur_o == $past(seg_i.dur))
    else $error("non-rom segment duration altered");

endmodule : hes_offset_adjust

// file: verilog/hes_sequencer.sv
`timescale 1ns/1ps
// Contract
// - launch starts playback from the first slot at 0x04; slots 0x04-0x0b
// - advance only to a non-zero slot; stop on zero or after eight
// - effect identifiers 1 to 127 index the rom library
// - slot top bit set means pause of low seven bits times 10 ms
// - time offsets at 0x0d-0x10 affect rom effects only
// - four signed 8-bit additive time offsets, zero by default
// - most positive segment is overdrive, most negative is brake
// - offsets apply to pairs and ramps; ramps use adjusted duration
// - real-time mode drives register amplitude until standby or mode change
// - real-time mode equals pwm mode with amplitude from register
// - analog input scales linearly, full scale equals 1.8 volts
// - continuous modes drive on entry, stop on standby or exit
// - writing launch flag at 0x0c starts; clearing it cancels
// - edge mode: rising pin edge sets launch; write clear still cancels
// - edge mode: rising edge while launch set cancels and clears it
// - edge mode: falling pin edge does nothing
// - level mode: launch flag follows the pin; fall cancels
// - supply measurement at 0x21 updated during playback
// - launch flag stays set while playing, clears on completion
// - continuous modes fire internally without touching launch bit
module hes_sequencer #(
  parameter int PAUSE_UNIT_CYC = hes_pkg::PAUSE_UNIT_CYCLES
) (
  // clock and reset
  input logic clk_i,
  input logic sys_rst_i,
  // register port behind the serial interface
  input logic reg_wr_i,
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // trigger and analog sources
  input logic trigger_input_pin_i,
  input logic [7:0] pwm_duty_i,
  input logic [7:0] adc_level_i,
  input logic [7:0] vdd_level_i,
  // playback engine
  input logic effect_done_i,
  input logic seg_req_i,
  input hes_pkg::hes_seg_t seg_i,
  output logic effect_start_o,
  output logic [6:0] effect_id_o,
  output logic effect_cancel_o,
  output logic rom_play_o,
  output logic fire_o,
  output logic drive_en_o,
  output logic [7:0] drive_amp_o,
  output logic adj_valid_o,
  output logic [15:0] adj_dur_o
);
  import hes_pkg::*;

  // register state
  logic [7:0] slots [0:SLOT_COUNT-1];
  logic [7:0] next_slots [0:SLOT_COUNT-1];
  hes_offsets_t offsets, next_offsets;
  hes_mode_t mode, next_mode;
  logic standby, next_standby;
  logic pwm_sel, next_pwm_sel;
  logic launch, next_launch;
  logic launch_prev;
  logic trig_prev;
  logic [7:0] rt_amp, next_rt_amp;
  logic [7:0] vdd, next_vdd;
  logic [7:0] next_rdata;
  logic [7:0] next_amp;
  logic next_fire, next_drive_en;
  // sequencer state
  hes_seq_state_t state, next_state;
  logic [2:0] idx, next_idx;
  logic [6:0] next_id;
  logic next_start, next_cancel, seq_done, pause_go, pause_done;
  logic abort, trig_rise, cont, wr_launch;
  logic [7:0] slot;
  logic [2:0] slot_sel;

  assign cont = hes_is_continuous(mode);
  assign trig_rise = trigger_input_pin_i && !trig_prev;
  assign wr_launch = reg_wr_i && (reg_addr_i == ADDR_LAUNCH);
  assign slot_sel = 3'(reg_addr_i - ADDR_SLOT_FIRST);
  assign slot = slots[idx];
  assign abort = !launch || standby || !hes_is_triggered(mode);

  always_comb
  begin
    next_slots = slots;
    next_offsets = offsets;
    next_mode = mode;
    next_standby = standby;
    next_pwm_sel = pwm_sel;
    next_rt_amp = rt_amp;
    next_launch = launch;
    if (reg_wr_i)
    begin
      if (reg_addr_i >= ADDR_SLOT_FIRST && reg_addr_i <= ADDR_SLOT_LAST)
        next_slots[slot_sel] = reg_wdata_i;
      case (reg_addr_i)
        ADDR_MODE:
        begin
          next_mode = hes_mode_t'(reg_wdata_i[2:0]);
          next_pwm_sel = reg_wdata_i[MODE_PWM_SEL_BIT];
          next_standby = reg_wdata_i[MODE_STANDBY_BIT];
        end
        ADDR_RT_AMP: next_rt_amp = reg_wdata_i;
        ADDR_OFS_OVERDRIVE: next_offsets.overdrive = reg_wdata_i;
        ADDR_OFS_SUSTAIN_POS: next_offsets.sustain_pos = reg_wdata_i;
        ADDR_OFS_SUSTAIN_NEG: next_offsets.sustain_neg = reg_wdata_i;
        ADDR_OFS_BRAKE: next_offsets.brake = reg_wdata_i;
        default: next_launch = launch;
      endcase
    end
    if (mode == MODE_LEVEL)
      next_launch = trigger_input_pin_i;
    else
    begin
      if (seq_done)
        next_launch = 1'b0;
      if (wr_launch)
        next_launch = reg_wdata_i[LAUNCH_BIT];
      // rising edge toggles; falling edge ignored
      if (mode == MODE_EDGE && trig_rise)
        next_launch = !launch;
    end
    if (standby)
      next_launch = 1'b0;
    next_vdd = drive_en_o ? vdd_level_i : vdd;
    // register amplitude; pwm duty; adc code is linear
    case (mode)
      MODE_RT_AMP: next_amp = rt_amp;
      MODE_ANALOG_PWM: next_amp = pwm_sel ? pwm_duty_i : adc_level_i;
      default: next_amp = 8'h00;
    endcase
    // continuous drive follows mode and standby
    next_drive_en = !standby && (cont || state == SEQ_PLAY || state == SEQ_PAUSE);
    next_fire = !standby && (cont || launch);
    case (reg_addr_i)
      ADDR_MODE: next_rdata = {1'b0, standby, 2'b00, pwm_sel, mode};
      ADDR_RT_AMP: next_rdata = rt_amp;
      ADDR_LAUNCH: next_rdata = {7'h00, launch};
      ADDR_OFS_OVERDRIVE: next_rdata = offsets.overdrive;
      ADDR_OFS_SUSTAIN_POS: next_rdata = offsets.sustain_pos;
      ADDR_OFS_SUSTAIN_NEG: next_rdata = offsets.sustain_neg;
      ADDR_OFS_BRAKE: next_rdata = offsets.brake;
      ADDR_VDD: next_rdata = vdd;
      default:
        next_rdata = (reg_addr_i >= ADDR_SLOT_FIRST && reg_addr_i <= ADDR_SLOT_LAST) ?
                     slots[slot_sel] : 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < SLOT_COUNT; i++)
        slots[i] <= RST_SLOT;
      offsets <= {4{RST_OFS}};
      mode <= MODE_INT;
      standby <= RST_STANDBY;
      pwm_sel <= RST_PWM_SEL;
      rt_amp <= RST_RT_AMP;
      launch <= 1'b0;
      launch_prev <= 1'b0;
      trig_prev <= 1'b0;
      vdd <= RST_VDD;
      reg_rdata_o <= 8'h00;
      drive_amp_o <= 8'h00;
      drive_en_o <= 1'b0;
      fire_o <= 1'b0;
    end
    else
    begin
      slots <= next_slots;
      offsets <= next_offsets;
      mode <= next_mode;
      standby <= next_standby;
      pwm_sel <= next_pwm_sel;
      rt_amp <= next_rt_amp;
      launch <= next_launch;
      launch_prev <= launch;
      trig_prev <= trigger_input_pin_i;
      vdd <= next_vdd;
      reg_rdata_o <= next_rdata;
      drive_amp_o <= next_amp;
      drive_en_o <= next_drive_en;
      fire_o <= next_fire;
    end
  end

  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_id = effect_id_o;
    next_start = 1'b0;
    next_cancel = 1'b0;
    seq_done = 1'b0;
    pause_go = 1'b0;
    case (state)
      SEQ_IDLE:
        // start at first slot; always from zero
        if (launch && !launch_prev && !abort)
        begin
          next_idx = 3'h0;
          next_state = SEQ_FETCH;
        end
      SEQ_FETCH:
        if (abort)
          next_state = SEQ_IDLE;
        else if (slot == 8'h00)
        begin
          seq_done = 1'b1;
          next_state = SEQ_IDLE;
        end
        else if (slot[SLOT_WAIT_BIT])
        begin
          pause_go = 1'b1;
          next_state = SEQ_PAUSE;
        end
        else
        begin
          next_id = slot[6:0];
          next_start = 1'b1;
          next_state = SEQ_PLAY;
        end
      SEQ_PLAY, SEQ_PAUSE:
        if (abort)
        begin
          next_cancel = (state == SEQ_PLAY);
          next_state = SEQ_IDLE;
        end
        // pause expiry advances like effect end
        else if ((state == SEQ_PLAY && effect_done_i) || (state == SEQ_PAUSE && pause_done))
        begin
          if (idx == 3'(SLOT_COUNT - 1))
          begin
            seq_done = 1'b1;
            next_state = SEQ_IDLE;
          end
          else
          begin
            next_idx = idx + 3'h1;
            next_state = SEQ_FETCH;
          end
        end
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= SEQ_IDLE;
      idx <= 3'h0;
      effect_id_o <= 7'h00;
      effect_start_o <= 1'b0;
      effect_cancel_o <= 1'b0;
      rom_play_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      effect_id_o <= next_id;
      effect_start_o <= next_start;
      effect_cancel_o <= next_cancel;
      rom_play_o <= (next_state == SEQ_PLAY);
    end
  end

  hes_pause_timer #(
    .UNIT_CYCLES(PAUSE_UNIT_CYC)
  ) u_pause (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(pause_go),
    .abort_i(abort),
    .units_i(slot[6:0]),
    .done_o(pause_done)
  );

  hes_offset_adjust u_offset (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .seg_req_i(seg_req_i),
    .seg_i(seg_i),
    .rom_play_i(rom_play_o),
    .offsets_i(offsets),
    .adj_valid_o(adj_valid_o),
    .adj_dur_o(adj_dur_o)
  );

  start_slot_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == SEQ_IDLE && launch && !launch_prev && !abort |=> state == SEQ_FETCH && idx == 3'h0)
    else $error("launch did not start at first slot");
  zero_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == SEQ_FETCH && slot == 8'h00 && !abort && mode != MODE_LEVEL && !wr_launch
    && !trig_rise |=> state == SEQ_IDLE && !launch)
    else $error("zero slot did not end sequence");
  last_slot_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == SEQ_PLAY && idx == 3'h7 && effect_done_i && !abort |=> state == SEQ_IDLE)
    else $error("sequence ran past eighth slot");
  id_range_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    effect_start_o |-> effect_id_o != 7'h00 && rom_play_o)
    else $error("effect started with identifier zero");
  pause_entry_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == SEQ_FETCH && slot[SLOT_WAIT_BIT] && !abort |=> state == SEQ_PAUSE ##1 !effect_start_o)
    else $error("wait slot played as effect");
  rt_amp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode == MODE_RT_AMP && !standby |=> drive_amp_o == $past(rt_amp))
    else $error("real-time amplitude not passed through");
  edge_cancel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode == MODE_EDGE && trig_rise && launch && !standby |=> !launch ##1 state == SEQ_IDLE)
    else $error("second edge did not cancel");
  level_track_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode == MODE_LEVEL && !standby |=> launch == $past(trigger_input_pin_i))
    else $error("launch flag not tracking pin");
  cont_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cont && !standby |=> drive_en_o)
    else $error("continuous mode not driving");
  fire_bit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cont && !standby && !wr_launch |=> fire_o && launch == $past(launch))
    else $error("continuous fire changed launch bit");
  vdd_track_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    drive_en_o |=> vdd == $past(vdd_level_i))
    else $error("supply report not updated during playback");

endmodule : hes_sequencer

// file: tb/hes_engine_model.sv
`timescale 1ns/1ps
module hes_engine_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // effect control from the sequencer
  input wire logic start_i,
  input wire logic cancel_i,
  input wire logic [7:0] delay_i,
  // completion back to the sequencer
  output logic done_o
);
  logic [7:0] cnt;
  logic busy;

  // a cancel must never be followed by a stale done pulse
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (sys_rst_i || cancel_i)
    begin
      busy <= 1'b0;
    end
    else if (start_i)
    begin
      busy <= 1'b1;
      cnt <= delay_i;
    end
    else if (busy && cnt == 8'h00)
    begin
      busy <= 1'b0;
      done_o <= 1'b1;
    end
    else if (busy)
    begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule : hes_engine_model

// file: tb/test_haptic_effect_sequencer_trigger.sv
`timescale 1ns/1ps
module test_haptic_effect_sequencer_trigger;
  import hes_pkg::*;
  // short pause unit keeps pause steps cheap in simulation
  localparam int PU = 4;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata;
  logic pin = 1'b0;
  logic [7:0] pwm = 8'h00;
  logic [7:0] adc = 8'h00;
  logic [7:0] vdd = 8'h00;
  logic done;
  logic seg_req = 1'b0;
  hes_seg_t seg = '0;
  logic start;
  logic [6:0] id;
  logic cancel;
  logic rom_play;
  logic fire;
  logic drive_en;
  logic [7:0] amp;
  logic adj_valid;
  logic [15:0] adj_dur;
  logic [7:0] eng_delay = 8'h02;
  logic [31:0] seed = 32'h39;
  logic [7:0] slot [8];
  logic [7:0] ofs [4];
  logic [6:0] ids [$];
  int tq [$];
  int cyc = 0;
  int n_cancel = 0;
  int fails = 0;
  int n_compared = 0;

  hes_sequencer #(.PAUSE_UNIT_CYC(PU)) hes_sequencer_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata), .trigger_input_pin_i(pin),
    .pwm_duty_i(pwm), .adc_level_i(adc), .vdd_level_i(vdd), .effect_done_i(done),
    .seg_req_i(seg_req), .seg_i(seg), .effect_start_o(start), .effect_id_o(id),
    .effect_cancel_o(cancel), .rom_play_o(rom_play), .fire_o(fire),
    .drive_en_o(drive_en), .drive_amp_o(amp), .adj_valid_o(adj_valid),
    .adj_dur_o(adj_dur));

  hes_engine_model hes_engine_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .start_i(start), .cancel_i(cancel), .delay_i(eng_delay), .done_o(done));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    if (fails == 0 && n_compared > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk_i)
  begin
    cyc++;
    if (start === 1'b1)
    begin
      ids.push_back(id);
      tq.push_back(cyc);
    end
    if (cancel === 1'b1)
    begin
      n_cancel++;
    end
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    rnd = seed[7:0];
  endfunction : rnd

  function automatic logic [7:0] rid();
    rid = (rnd() % 8'h7f) + 8'h01;
  endfunction : rid

  // offset is sign-extended and the result saturates at both ends
  function automatic logic [15:0] exp_adj(input logic [15:0] d, input logic [7:0] o);
    int s;
    s = int'(d) + int'($signed(o));
    exp_adj = (s < 0) ? 16'h0000 : (s > 65535) ? 16'hffff : 16'(s);
  endfunction : exp_adj

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_addr <= a;
    tick(2);
    #1;
    v = rdata;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask : chk_rd

  task automatic wait_idle();
    logic [7:0] v;
    v = 8'h01;
    for (int i = 0; i < 300 && v[0] !== 1'b0; i++)
    begin
      rd(ADDR_LAUNCH, v);
    end
  endtask : wait_idle

  task automatic load(input int k);
    for (int i = 0; i < 8; i++)
    begin
      slot[i] = (i < k) ? rid() : 8'h00;
      wr(ADDR_SLOT_FIRST + 8'(i), slot[i]);
    end
    ids.delete();
    tq.delete();
  endtask : load

  task automatic pin_set(input logic v);
    @(posedge clk_i);
    pin <= v;
  endtask : pin_set

  task automatic seg_go(input logic [15:0] d, input logic [7:0] lv, input logic [1:0] pk,
                        input logic [15:0] e);
    logic [7:0] r;
    r = rnd();
    @(posedge clk_i);
    seg_req <= 1'b1;
    seg <= '{d, lv, pk[1], pk[0], r[0]};
    @(posedge clk_i);
    seg_req <= 1'b0;
    #1;
    chk(adj_valid, 1'b1);
    chk(adj_dur, e);
  endtask : seg_go

  initial
  begin
    int k;
    int nc;
    logic [7:0] v;
    logic [15:0] d;
    tick(2);
    sys_rst_i <= 1'b0;
    for (int a = 13; a <= 16; a++)
    begin
      chk_rd(8'(a), RST_OFS);
    end
    chk_rd(8'h30, 8'h00);
    wr(ADDR_MODE, 8'h00);
    for (int t = 0; t < 3; t++)
    begin
      k = (t == 0) ? 8 : (t == 1) ? 1 : int'(rnd() % 8'h07) + 2;
      load(k);
      eng_delay = (rnd() % 8'h10) + 8'h01;
      wr(ADDR_LAUNCH, 8'h01);
      wait_idle();
      chk(16'(ids.size()), 16'(k));
      for (int i = 0; i < k && i < ids.size(); i++)
      begin
        chk(ids[i], slot[i][6:0]);
      end
      chk_rd(ADDR_LAUNCH, 8'h00);
    end
    load(3);
    wr(ADDR_SLOT_FIRST + 8'h01, 8'h82);
    eng_delay = 8'h03;
    wr(ADDR_LAUNCH, 8'h01);
    wait_idle();
    chk(16'(ids.size()), 16'h0002);
    chk(ids[1], slot[2][6:0]);
    chk(16'((tq[1] - tq[0]) inside {[3 + 2 * PU : 11 + 2 * PU]}), 16'h0001);
    load(2);
    eng_delay = 8'h3c;
    nc = n_cancel;
    wr(ADDR_LAUNCH, 8'h01);
    tick(10);
    wr(ADDR_LAUNCH, 8'h00);
    tick(4);
    chk(16'(n_cancel - nc), 16'h0001);
    chk(rom_play, 1'b0);
    ids.delete();
    eng_delay = 8'h02;
    wr(ADDR_LAUNCH, 8'h01);
    wait_idle();
    chk(ids[0], slot[0][6:0]);
    wr(ADDR_MODE, 8'h01);
    ids.delete();
    eng_delay = 8'h3c;
    pin_set(1'b1);
    tick(20);
    pin_set(1'b0);
    tick(6);
    chk(16'(ids.size()), 16'h0001);
    chk_rd(ADDR_LAUNCH, 8'h01);
    nc = n_cancel;
    pin_set(1'b1);
    tick(20);
    chk(16'(n_cancel - nc), 16'h0001);
    chk_rd(ADDR_LAUNCH, 8'h00);
    pin_set(1'b0);
    wr(ADDR_MODE, 8'h02);
    ids.delete();
    pin_set(1'b1);
    tick(8);
    chk(16'(ids.size()), 16'h0001);
    chk_rd(ADDR_LAUNCH, 8'h01);
    nc = n_cancel;
    pin_set(1'b0);
    tick(4);
    chk(16'(n_cancel - nc), 16'h0001);
    chk_rd(ADDR_LAUNCH, 8'h00);
    eng_delay = 8'h02;
    ids.delete();
    nc = n_cancel;
    pin_set(1'b1);
    tick(30);
    chk(16'(ids.size()), 16'h0002);
    chk(16'(n_cancel - nc), 16'h0000);
    pin_set(1'b0);
    wr(ADDR_MODE, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      ofs[i] = rnd();
      wr(ADDR_OFS_OVERDRIVE + 8'(i), ofs[i]);
      chk_rd(ADDR_OFS_OVERDRIVE + 8'(i), ofs[i]);
    end
    load(1);
    eng_delay = 8'hc8;
    wr(ADDR_LAUNCH, 8'h01);
    tick(6);
    d = {8'h00, rnd()};
    seg_go(d, 8'h10, 2'b10, exp_adj(d, ofs[0]));
    seg_go(16'hfff8, 8'h90, 2'b01, exp_adj(16'hfff8, ofs[3]));
    seg_go(16'h0003, 8'h10, 2'b00, exp_adj(16'h0003, ofs[1]));
    seg_go(d, 8'hf0, 2'b00, exp_adj(d, ofs[2]));
    wr(ADDR_LAUNCH, 8'h00);
    wr(ADDR_MODE, 8'h05);
    v = rnd();
    wr(ADDR_RT_AMP, v);
    tick(3);
    chk(amp, v);
    chk(drive_en, 1'b1);
    chk(fire, 1'b1);
    chk_rd(ADDR_LAUNCH, 8'h00);
    seg_go(16'h0100, 8'h10, 2'b10, 16'h0100);
    v = rnd();
    @(posedge clk_i);
    vdd <= v;
    tick(3);
    chk_rd(ADDR_VDD, v);
    wr(ADDR_MODE, 8'h04);
    tick(3);
    chk(drive_en, 1'b1);
    chk(fire, 1'b1);
    chk(amp, 8'h00);
    wr(ADDR_MODE, 8'h45);
    tick(3);
    chk(drive_en, 1'b0);
    wr(ADDR_MODE, 8'h03);
    foreach (slot[i])
    begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : (i == 2) ? 8'h00 : rnd();
      @(posedge clk_i);
      adc <= v;
      pwm <= ~v;
      tick(3);
      chk(amp, v);
    end
    wr(ADDR_MODE, 8'h0b);
    tick(3);
    chk(amp, 8'(~v));
    give_verdict();
  end
endmodule : test_haptic_effect_sequencer_trigger
